// [dv/fps_core_model.sv]
`timescale 1ns/10ps
module fps_core_model
(
    // from the block
    input  wire logic        mclk,
    input  wire logic        core_stall,
    input  wire logic        code_rvalid,
    input  wire logic [7:0]  code_rdata,
    // core requests
    output logic             ctl_wr,
    output logic [7:0]       ctl_wdata,
    output logic             prescale_wr,
    output logic [3:0]       prescale_wdata,
    output logic             xd_wr,
    output logic [15:0]      xd_addr,
    output logic [7:0]       xd_wdata,
    output logic             code_rd,
    output logic [15:0]      code_addr
);
    logic [7:0] rd_q;
    initial
    begin
        {ctl_wr, prescale_wr, xd_wr, code_rd, ctl_wdata, prescale_wdata} = '0;
        {xd_addr, xd_wdata, code_addr} = '0;
    end
    // k: 0 control, 1 prescaler, 2 data write, 3 code read; one op at a time
    task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        {ctl_wr, prescale_wr, xd_wr, code_rd} <= 4'h8 >> k;
        {ctl_wdata, prescale_wdata, xd_wdata} <= {d, d[3:0], d};
        {xd_addr, code_addr} <= {a, a};
        @(posedge mclk);
        {ctl_wr, prescale_wr, xd_wr, code_rd} <= 4'h0;
        #1;
        rd_q = code_rvalid ? code_rdata : 8'hxx;
        @(posedge mclk);
        #1;
        // a stalled core issues nothing, bounded so a stuck stall cannot hang here
        for (int i = 0; i < 3000 && core_stall; i++)
        begin
            @(posedge mclk);
            #1;
        end
    endtask
endmodule

// [dv/fps_sequencer_properties.sv]
`timescale 1ns/10ps
module fps_sequencer_properties
#(
    parameter int WRITE_CNT = 8,
    parameter int ERASE_CNT = 20
)
(
    // watched ports
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        ctl_wr,
    input wire logic [7:0]  ctl_wdata,
    input wire logic        prescale_wr,
    input wire logic        xd_wr,
    input wire logic [15:0] xd_addr,
    input wire logic        dbg_wr,
    input wire logic        code_rd,
    input wire logic        code_rvalid,
    input wire logic        core_stall,
    input wire logic        onchip_external_data_ram_wr,
    input wire logic [15:0] onchip_external_data_ram_addr,
    input wire logic [7:0]  program_store_control,
    input wire logic [3:0]  flash_timing_prescale_field
);
    int run_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk)
    begin
        if (!rst_n || !core_stall)
            run_q <= 0;
        else
            run_q <= run_q + 1;
    end
    // control outputs lag one cycle, so the enable seen here is stale after ctl_wr
    onchip_external_data_ram_fwd_a:
    assert property (xd_wr && !program_store_control[0] && !$past(ctl_wr)
        |=> onchip_external_data_ram_wr && onchip_external_data_ram_addr == $past(xd_addr)) else $error("data ram write lost");
    flash_no_fwd_a:
    assert property (xd_wr && program_store_control[0] && !$past(ctl_wr) |=> !onchip_external_data_ram_wr)
        else $error("flash write leaked to data ram");
    off_no_stall_a:
    assert property (flash_timing_prescale_field == 4'hf && !$past(prescale_wr) && !core_stall
        |=> !core_stall) else $error("stall while prescaler off");
    stall_len_a:
    assert property ($fell(core_stall) |-> run_q == WRITE_CNT + 16 * flash_timing_prescale_field
        || run_q == ERASE_CNT + 16 * flash_timing_prescale_field) else $error("bad stall length");
    stall_cause_a:
    assert property ($rose(core_stall) |-> $past(xd_wr) || $past(dbg_wr))
        else $error("stall without write");
    read_valid_a:
    assert property (code_rd |=> code_rvalid) else $error("read strobe missing");
    read_idle_a:
    assert property (!code_rd |=> !code_rvalid) else $error("read strobe without read");
    ctl_load_a:
    assert property (ctl_wr ##1 !ctl_wr |=> program_store_control == {6'h0, $past(ctl_wdata[1:0], 2)})
        else $error("control not loaded");
    ctl_sticky_a:
    assert property (!ctl_wr |-> ##2 $stable(program_store_control)) else $error("enable changed");
    cover property ($fell(core_stall) && run_q == ERASE_CNT + 16);
    cover property (onchip_external_data_ram_wr);
    cover property (code_rvalid);
endmodule
bind fps_sequencer fps_sequencer_properties #(.WRITE_CNT(WRITE_CNT), .ERASE_CNT(ERASE_CNT)) u_props (.*);

// [dv/test_flash_program_erase_sequencer.sv]
`timescale 1ns/10ps
module test_flash_program_erase_sequencer;
    import fps_pkg::*;
    typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} fps_row_t;
    localparam fps_row_t ROWS [4] = '{'{16'h0200, 8'h5a, 8'h5a}, '{16'h0200, 8'h0f, 8'h0a},
        '{16'h03ff, 8'h00, 8'h00}, '{16'h0201, 8'hff, 8'hff}};
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ctl_wr, prescale_wr, xd_wr, code_rd, code_rvalid, core_stall, onchip_external_data_ram_wr;
    logic [7:0]  ctl_wdata, xd_wdata, code_rdata, onchip_external_data_ram_wdata, program_store_control;
    logic [3:0]  prescale_wdata, flash_timing_prescale_field;
    logic [15:0] xd_addr, code_addr, onchip_external_data_ram_addr;
    logic [23:0] onchip_external_data_ram_seen = '0;
    logic        dbg_wr = 1'b0;
    logic [15:0] dbg_addr = 16'h0000;
    logic [7:0]  dbg_wdata = 8'h00;
    int          err_total = 0;
    int          checks_done = 0;
    int          run = 0;
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (core_stall)
            run <= run + 1;
        else if (xd_wr || dbg_wr)
            run <= 0;
        if (onchip_external_data_ram_wr)
            onchip_external_data_ram_seen <= {onchip_external_data_ram_addr, onchip_external_data_ram_wdata};
    end
    // debug erase held idle; debug byte program is driven below
    fps_sequencer #(.WRITE_CNT(8), .ERASE_CNT(20)) u_dut (.dbg_erase(1'b0), .*);
    fps_core_model u_core (.*);
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_core.op(2'h2, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        u_core.op(2'h3, a, 8'h00);
        chk(u_core.rd_q, e);
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(program_store_control, 8'h00);
        chk(flash_timing_prescale_field, PRESCALE_RESET);
        u_core.op(2'h0, 16'h0000, 8'h03);
        wr(16'h0200, 8'h00);
        chk(run, 0);
        u_core.op(2'h0, 16'h0000, 8'h00);
        wr(16'h1234, 8'ha5);
        chk(onchip_external_data_ram_seen, 24'h1234a5);
        u_core.op(2'h1, 16'h0000, 8'h01);
        u_core.op(2'h0, 16'h0000, 8'h03);
        wr(16'h0205, 8'h00);
        chk(run, 20 + 16);
        chk(program_store_control, 8'h03);
        rd(16'h0200, ERASED_BYTE);
        rd(16'h03ff, ERASED_BYTE);
        u_core.op(2'h0, 16'h0000, 8'h01);
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].d);
            chk(run, 8 + 16);
            rd(ROWS[i].a, ROWS[i].e);
        end
        u_core.op(2'h0, 16'h0000, 8'h03);
        wr(16'h8010, 8'h00);
        u_core.op(2'h0, 16'h0000, 8'h01);
        wr(16'h807f, 8'h3c);
        rd(16'h807f, 8'h3c);
        rd(XTRA_BASE, ERASED_BYTE);
        // debug program; the port moves on while the operation still runs
        @(posedge mclk);
        dbg_wr    <= 1'b1;
        dbg_addr  <= 16'h8001;
        dbg_wdata <= 8'h66;
        @(posedge mclk);
        dbg_wr    <= 1'b0;
        dbg_addr  <= 16'h8002;
        dbg_wdata <= 8'h00;
        repeat (30) @(posedge mclk);
        #1;
        chk(run, 8 + 16);
        rd(16'h8001, 8'h66);
        rd(16'h8002, ERASED_BYTE);
        wr(16'h8080, 8'h00);
        chk(run, 0);
        u_core.op(2'h1, 16'h0000, 8'h0f);
        wr(16'h807f, 8'h00);
        chk(run, 0);
        rd(16'h807f, 8'h3c);
        summarize();
    end
    initial
    begin
        #100000;
        err_total++;
        summarize();
    end
endmodule

// [hw/fps_sequencer.sv]
`timescale 1ns/10ps
// Function
// [R1] one byte programmed per data-space write
// [R2] program only while write enable set
// [R3] programming ANDs data, only erase sets
// [R4] erase whole 512-byte sector to 0xff
// [R5] erase when both enables set, data ignored
// [R6] erase enable stays until software clears
// [R7] operations self-timed, no polling needed
// [R8] duration scaled by 4-bit prescaler
// [R9] prescaler 1111b blocks all operations
// [R10] stall core while operation runs
// [R11] extra 128-byte sector at 0x8000
// [R12] reads via code-read port only
// [R13] debug port also programs the array
// [R14] software follows erase-then-write sequence
// [R15] 32k main array plus extra sector
// [R16] write enable clear routes to data RAM
// [R17] capture address and data until done
// [R18] blocked write leaves array, no stall
module fps_sequencer
#(
    parameter int WRITE_CNT = fps_pkg::WRITE_CYCLES,
    parameter int ERASE_CNT = fps_pkg::ERASE_CYCLES
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // control register writes from the core
    input  wire logic        ctl_wr,
    input  wire logic [7:0]  ctl_wdata,
    input  wire logic        prescale_wr,
    input  wire logic [3:0]  prescale_wdata,
    // external-data write cycle
    input  wire logic        xd_wr,
    input  wire logic [15:0] xd_addr,
    input  wire logic [7:0]  xd_wdata,
    // code read cycle
    input  wire logic        code_rd,
    input  wire logic [15:0] code_addr,
    // debug port programming
    input  wire logic        dbg_wr,
    input  wire logic        dbg_erase,
    input  wire logic [15:0] dbg_addr,
    input  wire logic [7:0]  dbg_wdata,
    // outputs
    output logic [7:0]       code_rdata,
    output logic             code_rvalid,
    output logic             core_stall,
    output logic             onchip_external_data_ram_wr,
    output logic [15:0]      onchip_external_data_ram_addr,
    output logic [7:0]       onchip_external_data_ram_wdata,
    output logic [7:0]       program_store_control,
    output logic [3:0]       flash_timing_prescale_field
);
    import fps_pkg::*;

    localparam int DEPTH = MAIN_BYTES + XTRA_BYTES;

    // refuse settings the counter, the sector mask or the index map cannot serve
    if (WRITE_CNT < 1)
    begin : g_bad_write_low
        $error("fps_sequencer: write count below one");
    end

    if (ERASE_CNT < 1)
    begin : g_bad_erase_low
        $error("fps_sequencer: erase count below one");
    end

    // the prescaler adds up to fifteen steps on top of the base count
    if (WRITE_CNT > (1 << (CNT_W - 4)))
    begin : g_bad_write_high
        $error("fps_sequencer: write count too large for counter");
    end

    if (ERASE_CNT > (1 << (CNT_W - 4)))
    begin : g_bad_erase_high
        $error("fps_sequencer: erase count too large for counter");
    end

    // sector base is found by masking, so the size must be a power of two
    if ((MAIN_SECT_BYTES & (MAIN_SECT_BYTES - 1)) != 0)
    begin : g_bad_sector_size
        $error("fps_sequencer: sector size not a power of two");
    end

    if ((MAIN_BYTES % MAIN_SECT_BYTES) != 0)
    begin : g_bad_main_size
        $error("fps_sequencer: main array not whole sectors");
    end

    if (int'(XTRA_LAST - XTRA_BASE) + 1 != XTRA_BYTES)
    begin : g_bad_xtra_size
        $error("fps_sequencer: extra sector bounds disagree with size");
    end

    // the extra sector is stored right after the main array
    if (int'(XTRA_BASE) != MAIN_BYTES)
    begin : g_bad_xtra_base
        $error("fps_sequencer: extra sector must follow main array");
    end

    if (DEPTH > 65536)
    begin : g_bad_depth
        $error("fps_sequencer: array deeper than the address space");
    end

    if (CTL_WE_BIT > 7 || CTL_EE_BIT > 7)
    begin : g_bad_ctl_bits
        $error("fps_sequencer: control bit outside the control byte");
    end

    logic [7:0]       mem [DEPTH];
    fps_state_t       state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [15:0]      op_addr_q;
    logic [7:0]       op_data_q;
    logic             ctl_we_q;
    logic             ctl_ee_q;
    logic [3:0]       pre_q;

    // valid array addresses: main 32k or the extra sector
    function automatic logic in_array(input logic [15:0] a);
        in_array = (a < 16'(MAIN_BYTES)) || (a >= XTRA_BASE && a <= XTRA_LAST); // see [R15] [R11]
    endfunction

    function automatic logic [15:0] idx(input logic [15:0] a);
        idx = (a >= XTRA_BASE) ? (a - XTRA_BASE + 16'(MAIN_BYTES)) : a;
    endfunction

    logic busy;
    logic enabled;
    logic cpu_go;
    logic dbg_go;
    logic go;
    logic go_erase;
    logic [15:0] go_addr;
    logic [7:0]  go_data;
    logic [CNT_W-1:0] base_cnt;

    assign busy     = (state_q != FPS_IDLE);
    assign enabled  = (pre_q != PRESCALE_OFF); // see [R9] [R18]
    assign cpu_go   = xd_wr && ctl_we_q && in_array(xd_addr); // see [R1] [R2]
    assign dbg_go   = (dbg_wr || dbg_erase) && in_array(dbg_addr); // see [R13]
    // debug port wins when both arrive together
    assign go       = !busy && enabled && (cpu_go || dbg_go);
    assign go_erase = dbg_go ? dbg_erase : ctl_ee_q; // see [R5]
    assign go_addr  = dbg_go ? dbg_addr : xd_addr;
    assign go_data  = dbg_go ? dbg_wdata : xd_wdata;
    // duration grows with the prescaler code; the step keeps lower codes short
    assign base_cnt = go_erase ? CNT_W'(ERASE_CNT) : CNT_W'(WRITE_CNT);

    // control register bits hold until software writes them
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctl_we_q <= CTL_RESET[CTL_WE_BIT];
            ctl_ee_q <= CTL_RESET[CTL_EE_BIT];
        end
        else if (ctl_wr)
        begin
            ctl_we_q <= ctl_wdata[CTL_WE_BIT]; // see [R2]
            ctl_ee_q <= ctl_wdata[CTL_EE_BIT]; // see [R6]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pre_q <= PRESCALE_RESET;
        else if (prescale_wr)
            pre_q <= prescale_wdata; // see [R8]
    end

    // mirrors of the control bits, one flop behind
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            program_store_control <= CTL_RESET;
        else
            program_store_control <= {6'h00, ctl_ee_q, ctl_we_q};
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            flash_timing_prescale_field <= PRESCALE_RESET;
        else
            flash_timing_prescale_field <= pre_q;
    end

    // operation state: idle until a request is taken, back at the last count
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_q <= FPS_IDLE;
        else
        begin
            unique case (state_q)
                FPS_IDLE:
                begin
                    if (go)
                        state_q <= go_erase ? FPS_ERASE : FPS_WRITE;
                end
                FPS_WRITE, FPS_ERASE:
                begin
                    if (cnt_q == CNT_W'(1))
                        state_q <= FPS_IDLE; // see [R7]
                end
            endcase
        end
    end

    // cycle counter; longer hold for higher prescaler codes
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (go)
            cnt_q <= base_cnt + CNT_W'({pre_q, 4'h0}); // see [R7] [R8]
        else if (busy)
            cnt_q <= cnt_q - CNT_W'(1);
    end

    // request captured once; the core may move its bus while stalled
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            op_addr_q <= 16'h0000;
            op_data_q <= 8'h00;
        end
        else if (go)
        begin
            op_addr_q <= go_addr; // see [R17]
            op_data_q <= go_data; // see [R17]
        end
    end

    // array update at the last cycle of the operation
    logic last;
    logic xtra_op;
    logic [15:0] sect_base;
    logic [15:0] sect_len;
    assign last      = busy && (cnt_q == CNT_W'(1));
    assign xtra_op   = (op_addr_q >= XTRA_BASE);
    assign sect_base = xtra_op ? 16'(MAIN_BYTES)
                               : (op_addr_q & ~16'(MAIN_SECT_BYTES - 1));
    assign sect_len  = xtra_op ? 16'(XTRA_BYTES) : 16'(MAIN_SECT_BYTES);

    // no reset: contents are nonvolatile
    always_ff @(posedge mclk)
    begin
        if (last && state_q == FPS_WRITE)
            mem[idx(op_addr_q)] <= mem[idx(op_addr_q)] & op_data_q; // see [R3]
        else if (last && state_q == FPS_ERASE)
        begin
            for (int i = 0; i < DEPTH; i++)
                if (16'(i) >= sect_base && 16'(i) < sect_base + sect_len)
                    mem[i] <= ERASED_BYTE; // see [R4] [R11]
        end
    end

    // stall from the taken write until the operation ends
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            core_stall <= 1'b0;
        else if (go)
            core_stall <= 1'b1; // see [R10]
        else if (last)
            core_stall <= 1'b0; // see [R10]
    end

    // code reads return array contents; reads outside the array give zero
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            code_rvalid <= 1'b0;
        else
            code_rvalid <= code_rd;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            code_rdata <= 8'h00;
        else if (code_rd && in_array(code_addr))
            code_rdata <= mem[idx(code_addr)]; // see [R12]
        else
            code_rdata <= 8'h00;
    end

    // data-space writes go to the data RAM while write enable is clear
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            onchip_external_data_ram_wr <= 1'b0;
        else
            onchip_external_data_ram_wr <= xd_wr && !ctl_we_q; // see [R16]
    end

    // address and data follow the bus; only the strobe qualifies them
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            onchip_external_data_ram_addr  <= 16'h0000;
            onchip_external_data_ram_wdata <= 8'h00;
        end
        else
        begin
            onchip_external_data_ram_addr  <= xd_addr;
            onchip_external_data_ram_wdata <= xd_wdata;
        end
    end
endmodule

// [shared/fps_pkg.sv]
package fps_pkg;
    // array geometry
    localparam int          MAIN_BYTES      = 32768;
    localparam int          MAIN_SECT_BYTES = 512;
    localparam int          XTRA_BYTES      = 128;
    localparam logic [15:0] XTRA_BASE       = 16'h8000;
    localparam logic [15:0] XTRA_LAST       = 16'h807f;
    localparam logic [7:0]  ERASED_BYTE     = 8'hff;
    // control bit positions and reset values
    localparam int          CTL_WE_BIT      = 0;
    localparam int          CTL_EE_BIT      = 1;
    localparam logic [7:0]  CTL_RESET       = 8'h00;
    localparam logic [3:0]  PRESCALE_RESET  = 4'hf;
    localparam logic [3:0]  PRESCALE_OFF    = 4'hf;
    // timing, from the electrical table
    localparam int          CLK_MHZ         = 100;
    localparam int          WRITE_TIME_US   = 40;
    localparam int          ERASE_TIME_MS   = 10;
    localparam int          WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;
    localparam int          ERASE_CYCLES    = ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int          CNT_W           = 24;

    typedef enum logic [2:0]
    {
        FPS_IDLE  = 3'b001,
        FPS_WRITE = 3'b010,
        FPS_ERASE = 3'b100
    } fps_state_t;
endpackage
